/* File: rtl/pivm_addr_dec.v */
// Peripheral base-address window decode
`timescale 1ns/100ps
`include "pivm_consts.vh"
module pivm_addr_dec (
  // Bus address
  input  wire [`PIVM_ADDR_W-1:0] addr_i,
  input  wire                    big_pkg_i,
  // Window selects and offset
  output reg  [`PIVM_WIN_N-1:0]  win_sel_o,
  output reg  [`PIVM_ADDR_W-1:0] win_off_o
);

  function hit;
    input [`PIVM_ADDR_W-1:0] a;
    input [`PIVM_ADDR_W-1:0] base;
    input [`PIVM_ADDR_W-1:0] size;
    begin
      hit = (a >= base) && ((a - base) < size);
    end
  endfunction

  always @* begin
    win_sel_o = {`PIVM_WIN_N{1'b0}};
    win_off_o = {`PIVM_ADDR_W{1'b0}};
    win_sel_o[`PIVM_WIN_GPR]   = hit(addr_i, `PIVM_BASE_GPR, `PIVM_SIZE_GPR);
    win_sel_o[`PIVM_WIN_MSCAN] = hit(addr_i, `PIVM_BASE_MSCAN, `PIVM_SIZE_MSCAN);
    win_sel_o[`PIVM_WIN_SX0]   = hit(addr_i, `PIVM_BASE_SX0, `PIVM_SIZE_SX0);
    win_sel_o[`PIVM_WIN_TA0]   = hit(addr_i, `PIVM_BASE_TA0, `PIVM_SIZE_TA0);
    // Only the largest package carries this timer window
    win_sel_o[`PIVM_WIN_TB3]   = big_pkg_i &&
                                 hit(addr_i, `PIVM_BASE_TB3, `PIVM_SIZE_TB3);
    // Register address is base plus offset
    if (win_sel_o[`PIVM_WIN_GPR])
      win_off_o = addr_i - `PIVM_BASE_GPR;
    else if (win_sel_o[`PIVM_WIN_MSCAN])
      win_off_o = addr_i - `PIVM_BASE_MSCAN;
    else if (win_sel_o[`PIVM_WIN_SX0])
      win_off_o = addr_i - `PIVM_BASE_SX0;
    else if (win_sel_o[`PIVM_WIN_TA0])
      win_off_o = addr_i - `PIVM_BASE_TA0;
    else if (win_sel_o[`PIVM_WIN_TB3])
      win_off_o = addr_i - `PIVM_BASE_TB3;
  end

endmodule // pivm_addr_dec

/* File: rtl/pivm_consts.vh */
// Constants for the peripheral interrupt vector map and base-address decode
`ifndef PIVM_CONSTS_VH
`define PIVM_CONSTS_VH

// ----------------------------------------
// Vector numbers and program addresses
// ----------------------------------------
`define PIVM_VEC_W          2
`define PIVM_VEC_RESET      2'h0
`define PIVM_VEC_NMI        2'h1
`define PIVM_VEC_VLM        2'h2
`define PIVM_VEC_RTC        2'h3
`define PIVM_PADDR_W        8
`define PIVM_PADDR_NMI      8'h02
`define PIVM_PADDR_VLM      8'h04
`define PIVM_PADDR_RTC      8'h06

// ----------------------------------------
// Flag register layout per source
// ----------------------------------------
`define PIVM_MS_FLAG_NMI    0
`define PIVM_VLM_FLAG       0
`define PIVM_RTC_FLAG_OVF   0
`define PIVM_RTC_FLAG_CMP   1
`define PIVM_RTC_SRC_N      2
`define PIVM_FLAG_RST       2'h0
`define PIVM_EN_RST         2'h0

// ----------------------------------------
// Peripheral base addresses and window sizes
// ----------------------------------------
`define PIVM_ADDR_W         16
`define PIVM_BASE_GPR       16'h001C
`define PIVM_SIZE_GPR       16'h0004
`define PIVM_BASE_MSCAN     16'h0120
`define PIVM_SIZE_MSCAN     16'h0020
`define PIVM_BASE_SX0       16'h0800
`define PIVM_SIZE_SX0       16'h0020
`define PIVM_BASE_TA0       16'h0A00
`define PIVM_SIZE_TA0       16'h0080
`define PIVM_BASE_TB3       16'h0AB0
`define PIVM_SIZE_TB3       16'h0010
`define PIVM_WIN_N          5
`define PIVM_WIN_GPR        0
`define PIVM_WIN_MSCAN      1
`define PIVM_WIN_SX0        2
`define PIVM_WIN_TA0        3
`define PIVM_WIN_TB3        4

`endif

/* File: rtl/pivm_src_flags.v */
// One interrupt source group: sticky flags, enable bits and request output
`timescale 1ns/100ps
module pivm_src_flags #(
  parameter N = 2
) (
  // Clock and reset
  input  wire         clock_i,
  input  wire         sys_rst_i,
  input  wire         clk_en_i,
  // Peripheral events and software access
  input  wire [N-1:0] event_i,
  input  wire [N-1:0] flag_clr_i,
  input  wire         en_wr_i,
  input  wire [N-1:0] en_wdata_i,
  // State and request
  output reg  [N-1:0] irq_flag_reg,
  output reg  [N-1:0] irq_enable_reg,
  output wire         req_o
);

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_flag_reg   <= {N{1'b0}};
      irq_enable_reg <= {N{1'b0}};
    end else if (clk_en_i) begin
      // A set in the clearing cycle wins so no event is lost
      irq_flag_reg <= (irq_flag_reg & ~flag_clr_i) | event_i;
      if (en_wr_i) begin
        irq_enable_reg <= en_wdata_i;
      end
    end
  end

  // Request stays up until the flag or the enable bit clears, handler entry has no effect
  assign req_o = |(irq_flag_reg & irq_enable_reg);

endmodule // pivm_src_flags

/* File: rtl/pivm_top.v */
// Interrupt request generation, vector mapping and peripheral window decode
`timescale 1ns/100ps
`include "pivm_consts.vh"

// Contract
// - A detected peripheral condition sets its flag in that peripheral's flag register.
// - Software writes per-source enable bits; they hold until rewritten.
// - A request is raised only while enable bit and flag are both set.
// - A request stays until its flag or its enable bit clears; handler entry does not drop it.
// - Maskable requests reach the core only with global enable set.
// - Each vector slot serves one peripheral instance; its sources may share it.
// - Vector 1 at address 0x02 is the memory-scan non-maskable, ungated globally.
// - Vector 2 at address 0x04 carries the voltage level monitor interrupt.
// - Vector 3 at address 0x06 is the counter, shared by overflow and compare.
// - Each peripheral window starts at its base; register address is base plus offset.
// - General purpose storage registers decode from base 0x001C.
// - Memory-scan checker window decodes from base 0x0120.
// - First serial transceiver window starts at base 0x0800.
// - Type A timer window starts at base 0x0A00.
// - Fourth type B timer window starts at 0x0AB0, largest package only.
module pivm_top (
  // Clock, reset and enable
  input  wire                            clock_i,
  input  wire                            sys_rst_i,
  input  wire                            clk_en_i,
  // Core global enable
  input  wire                            global_irq_en_i,
  // Peripheral events
  input  wire                            memscan_err_i,
  input  wire                            vlm_event_i,
  input  wire [`PIVM_RTC_SRC_N-1:0]      rtc_event_i,
  // Software flag clears and enable writes
  input  wire                            vlm_flag_clr_i,
  input  wire [`PIVM_RTC_SRC_N-1:0]      rtc_flag_clr_i,
  input  wire                            memscan_flag_clr_i,
  input  wire                            vlm_en_wr_i,
  input  wire                            vlm_en_wdata_i,
  input  wire                            rtc_en_wr_i,
  input  wire [`PIVM_RTC_SRC_N-1:0]      rtc_en_wdata_i,
  // Address decode
  input  wire [`PIVM_ADDR_W-1:0]         addr_i,
  input  wire                            big_pkg_i,
  output wire [`PIVM_WIN_N-1:0]          win_sel_o,
  output wire [`PIVM_ADDR_W-1:0]         win_off_o,
  // Flag and enable state
  output wire                            memscan_flag_o,
  output wire                            vlm_flag_o,
  output wire                            vlm_en_o,
  output wire [`PIVM_RTC_SRC_N-1:0]      rtc_flag_o,
  output wire [`PIVM_RTC_SRC_N-1:0]      rtc_en_o,
  // Core interrupt interface
  output wire                            irq_req_o,
  output reg  [`PIVM_VEC_W-1:0]          irq_vec_o,
  output reg  [`PIVM_PADDR_W-1:0]        irq_paddr_o
);

  // ----------------------------------------
  // Source groups
  // ----------------------------------------
  wire vlm_req;
  wire rtc_req;
  wire ms_req;

  // Non-maskable source: its enable is tied on by design
  pivm_src_flags #(.N(1)) u_memscan (
    .clock_i        (clock_i),
    .sys_rst_i      (sys_rst_i),
    .clk_en_i       (clk_en_i),
    .event_i        (memscan_err_i),
    .flag_clr_i     (memscan_flag_clr_i),
    .en_wr_i        (1'b1),
    .en_wdata_i     (1'b1),
    .irq_flag_reg   (memscan_flag_o),
    .irq_enable_reg (),
    .req_o          (ms_req)
  );

  pivm_src_flags #(.N(1)) u_vlm (
    .clock_i        (clock_i),
    .sys_rst_i      (sys_rst_i),
    .clk_en_i       (clk_en_i),
    .event_i        (vlm_event_i),
    .flag_clr_i     (vlm_flag_clr_i),
    .en_wr_i        (vlm_en_wr_i),
    .en_wdata_i     (vlm_en_wdata_i),
    .irq_flag_reg   (vlm_flag_o),
    .irq_enable_reg (vlm_en_o),
    .req_o          (vlm_req)
  );

  // Overflow and compare share one slot
  pivm_src_flags #(.N(`PIVM_RTC_SRC_N)) u_rtc (
    .clock_i        (clock_i),
    .sys_rst_i      (sys_rst_i),
    .clk_en_i       (clk_en_i),
    .event_i        (rtc_event_i),
    .flag_clr_i     (rtc_flag_clr_i),
    .en_wr_i        (rtc_en_wr_i),
    .en_wdata_i     (rtc_en_wdata_i),
    .irq_flag_reg   (rtc_flag_o),
    .irq_enable_reg (rtc_en_o),
    .req_o          (rtc_req)
  );

  // ----------------------------------------
  // Vector selection
  // ----------------------------------------
  wire nmi_pend;
  wire vlm_pend;
  wire rtc_pend;

  assign nmi_pend = ms_req;
  assign vlm_pend = vlm_req & global_irq_en_i;
  assign rtc_pend = rtc_req & global_irq_en_i;

  // Request is combinational so it drops the cycle the flag clears
  assign irq_req_o = nmi_pend | vlm_pend | rtc_pend;

  reg [`PIVM_VEC_W-1:0]   next_vec;
  reg [`PIVM_PADDR_W-1:0] next_paddr;

  always @* begin
    next_vec   = `PIVM_VEC_RESET;
    next_paddr = {`PIVM_PADDR_W{1'b0}};
    if (nmi_pend) begin
      next_vec   = `PIVM_VEC_NMI;
      next_paddr = `PIVM_PADDR_NMI;
    end else if (vlm_pend) begin
      next_vec   = `PIVM_VEC_VLM;
      next_paddr = `PIVM_PADDR_VLM;
    end else if (rtc_pend) begin
      next_vec   = `PIVM_VEC_RTC;
      next_paddr = `PIVM_PADDR_RTC;
    end
  end

  // Vector data registered; lags irq_req_o by one cycle
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_vec_o   <= `PIVM_VEC_RESET;
      irq_paddr_o <= {`PIVM_PADDR_W{1'b0}};
    end else if (clk_en_i) begin
      irq_vec_o   <= next_vec;
      irq_paddr_o <= next_paddr;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  pivm_addr_dec u_dec (
    .addr_i    (addr_i),
    .big_pkg_i (big_pkg_i),
    .win_sel_o (win_sel_o),
    .win_off_o (win_off_o)
  );

endmodule // pivm_top

/* File: sim/periph_irq_vector_map_bench.sv */
// Self-checking testbench for the interrupt vector map
`timescale 1ns/100ps
module periph_irq_vector_map_bench;
  logic clock_i, sys_rst_i, clk_en_i, global_irq_en_i, memscan_err_i, vlm_event_i;
  logic vlm_flag_clr_i, memscan_flag_clr_i, vlm_en_wr_i, vlm_en_wdata_i, rtc_en_wr_i;
  logic big_pkg_i, memscan_flag_o, vlm_flag_o, vlm_en_o, irq_req_o;
  logic [1:0]  rtc_event_i, rtc_flag_clr_i, rtc_en_wdata_i, rtc_flag_o, rtc_en_o, irq_vec_o;
  logic [15:0] addr_i, win_off_o;
  logic [4:0]  win_sel_o;
  logic [7:0]  irq_paddr_o, fetch;
  int          err_count, checked;
  pivm_top i_dut (.*);
  pivm_core_model i_core (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(irq_req_o),
    .vec_i(irq_vec_o), .paddr_i(irq_paddr_o), .fetch_o(fetch));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task nc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task t_decode;
    logic [15:0] base [5];
    logic [15:0] size [5];
    base = '{16'h001C, 16'h0120, 16'h0800, 16'h0A00, 16'h0AB0};
    size = '{16'h0004, 16'h0020, 16'h0020, 16'h0080, 16'h0010};
    for (int i = 0; i < 5; i++) begin
      addr_i = base[i];
      nc(1);
      chk(win_sel_o, 16'h0001 << i);
      chk(win_off_o, 16'h0000);
      addr_i = base[i] + size[i] - 16'h0001;
      nc(1);
      chk(win_sel_o, 16'h0001 << i);
      chk(win_off_o, size[i] - 16'h0001);
      addr_i = base[i] + size[i];
      nc(1);
      chk(win_sel_o[i], 16'h0000);
      addr_i = base[i] - 16'h0001;
      nc(1);
      chk(win_sel_o[i], 16'h0000);
    end
    big_pkg_i = 1'b0;
    addr_i = 16'h0AB0;
    nc(1);
    chk(win_sel_o, 16'h0000);
    chk(win_off_o, 16'h0000);
  endtask
  task t_vlm;
    vlm_en_wr_i = 1'b1;
    vlm_en_wdata_i = 1'b1;
    vlm_event_i = 1'b1;
    nc(1);
    vlm_en_wr_i = 1'b0;
    vlm_event_i = 1'b0;
    chk(vlm_flag_o, 16'h0001);
    chk(irq_req_o, 16'h0000);
    global_irq_en_i = 1'b1;
    nc(1);
    chk(irq_req_o, 16'h0001);
    chk({irq_vec_o, irq_paddr_o}, 16'h0204);
    nc(1);
    chk(fetch, 16'h0004);
    chk(irq_req_o, 16'h0001);
    vlm_en_wr_i = 1'b1;
    vlm_en_wdata_i = 1'b0;
    nc(1);
    vlm_en_wr_i = 1'b0;
    chk({vlm_flag_o, irq_req_o}, 16'h0002);
  endtask
  task t_rtc;
    rtc_en_wr_i = 1'b1;
    rtc_en_wdata_i = 2'h1;
    rtc_event_i = 2'h3;
    vlm_flag_clr_i = 1'b1;
    nc(1);
    rtc_en_wr_i = 1'b0;
    rtc_event_i = 2'h0;
    vlm_flag_clr_i = 1'b0;
    nc(1);
    chk({rtc_flag_o, irq_vec_o, irq_paddr_o}, 16'h0F06);
    rtc_flag_clr_i = 2'h1;
    nc(1);
    rtc_flag_clr_i = 2'h0;
    chk({rtc_flag_o, irq_req_o}, 16'h0004);
    rtc_en_wr_i = 1'b1;
    rtc_en_wdata_i = 2'h2;
    nc(1);
    rtc_en_wr_i = 1'b0;
    chk(irq_req_o, 16'h0001);
    chk(rtc_en_o, 16'h0002);
    nc(1);
    chk({irq_vec_o, irq_paddr_o}, 16'h0306);
    rtc_flag_clr_i = 2'h3;
    nc(1);
    rtc_flag_clr_i = 2'h0;
    chk(irq_req_o, 16'h0000);
  endtask
  task t_nmi;
    global_irq_en_i = 1'b0;
    vlm_en_wr_i = 1'b1;
    vlm_en_wdata_i = 1'b1;
    vlm_event_i = 1'b1;
    memscan_err_i = 1'b1;
    nc(1);
    vlm_en_wr_i = 1'b0;
    vlm_event_i = 1'b0;
    memscan_err_i = 1'b0;
    chk(irq_req_o, 16'h0001);
    chk(memscan_flag_o, 16'h0001);
    chk(vlm_en_o, 16'h0001);
    nc(1);
    chk({irq_vec_o, irq_paddr_o}, 16'h0102);
    memscan_flag_clr_i = 1'b1;
    global_irq_en_i = 1'b1;
    nc(1);
    memscan_flag_clr_i = 1'b0;
    nc(1);
    chk({irq_vec_o, irq_paddr_o}, 16'h0204);
  endtask
  // Mid-run reset, then a frozen clock enable must hold the monitor flag and enable
  task t_reset;
    sys_rst_i = 1'b1;
    nc(1);
    chk({memscan_flag_o, vlm_flag_o, vlm_en_o, rtc_flag_o, rtc_en_o}, 16'h0000);
    chk({irq_req_o, irq_vec_o, irq_paddr_o}, 16'h0000);
    chk(fetch, 16'h0000);
    sys_rst_i = 1'b0;
    clk_en_i = 1'b0;
    vlm_event_i = 1'b1;
    vlm_en_wr_i = 1'b1;
    vlm_en_wdata_i = 1'b1;
    nc(2);
    chk({vlm_flag_o, vlm_en_o}, 16'h0000);
    clk_en_i = 1'b1;
    nc(1);
    vlm_event_i = 1'b0;
    vlm_en_wr_i = 1'b0;
    chk({vlm_flag_o, vlm_en_o}, 16'h0003);
  endtask
  initial begin
    {sys_rst_i, clk_en_i, big_pkg_i} = 3'h7;
    {global_irq_en_i, memscan_err_i, vlm_event_i, vlm_flag_clr_i} = 4'h0;
    {memscan_flag_clr_i, vlm_en_wr_i, vlm_en_wdata_i, rtc_en_wr_i} = 4'h0;
    {rtc_event_i, rtc_flag_clr_i, rtc_en_wdata_i} = 6'h00;
    addr_i = 16'h0000;
    err_count = 0;
    checked = 0;
    nc(3);
    sys_rst_i = 1'b0;
    chk({irq_req_o, irq_vec_o, irq_paddr_o}, 16'h0000);
    t_decode();
    t_vlm();
    t_rtc();
    t_nmi();
    t_reset();
    stop_test();
  end
  // Whole run is well under a hundred cycles
  initial begin
    #4000;
    err_count++;
    stop_test();
  end
endmodule // periph_irq_vector_map_bench

/* File: sim/pivm_checker.sv */
// Assertion checker for the interrupt vector map
`timescale 1ns/100ps
module pivm_checker (
  // Clock and control
  input logic        clock_i,
  input logic        sys_rst_i,
  input logic        clk_en_i,
  input logic        global_irq_en_i,
  // Stimulus
  input logic        vlm_event_i,
  input logic        vlm_flag_clr_i,
  input logic        vlm_en_wr_i,
  input logic        vlm_en_wdata_i,
  input logic [15:0] addr_i,
  // Observed outputs
  input logic [4:0]  win_sel_o,
  input logic [15:0] win_off_o,
  input logic        memscan_flag_o,
  input logic        vlm_flag_o,
  input logic        vlm_en_o,
  input logic [1:0]  rtc_flag_o,
  input logic [1:0]  rtc_en_o,
  input logic        irq_req_o,
  input logic [1:0]  irq_vec_o,
  input logic [7:0]  irq_paddr_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  wire vlm_p = vlm_flag_o & vlm_en_o;
  wire rtc_p = |(rtc_flag_o & rtc_en_o);
  sequence s_vlm_top;
    clk_en_i && global_irq_en_i && !memscan_flag_o && vlm_p;
  endsequence
  sequence s_rtc_top;
    clk_en_i && global_irq_en_i && !memscan_flag_o && !vlm_p && rtc_p;
  endsequence
  a_req_level: assert property (
    irq_req_o == (memscan_flag_o | global_irq_en_i & (vlm_p | rtc_p)))
    else $error("request level wrong");
  a_flag_set: assert property (clk_en_i && vlm_event_i |=> vlm_flag_o)
    else $error("flag not set");
  a_flag_hold: assert property (vlm_flag_o && !vlm_flag_clr_i |=> vlm_flag_o)
    else $error("flag dropped");
  a_en_write: assert property (
    clk_en_i && vlm_en_wr_i |=> vlm_en_o == $past(vlm_en_wdata_i))
    else $error("enable write lost");
  a_nmi_first: assert property (
    clk_en_i && memscan_flag_o |=> irq_vec_o == 2'h1 && irq_paddr_o == 8'h02)
    else $error("nmi vector wrong");
  a_vlm_vec: assert property (s_vlm_top |=> irq_vec_o == 2'h2 && irq_paddr_o == 8'h04)
    else $error("monitor vector wrong");
  a_rtc_vec: assert property (s_rtc_top |=> irq_vec_o == 2'h3 && irq_paddr_o == 8'h06)
    else $error("counter vector wrong");
  a_gpr_win: assert property (
    addr_i >= 16'h001C && addr_i <= 16'h001F |->
      win_sel_o == 5'h01 && win_off_o == addr_i - 16'h001C)
    else $error("storage window wrong");
endmodule // pivm_checker

bind pivm_top pivm_checker i_chk (.*);

/* File: sim/pivm_core_model.sv */
// Processor core model that fetches the presented vector address
`timescale 1ns/100ps
module pivm_core_model (
  // Clock and reset
  input  logic       clock_i,
  input  logic       sys_rst_i,
  // Request from the map
  input  logic       req_i,
  input  logic [1:0] vec_i,
  input  logic [7:0] paddr_i,
  // Last fetched address
  output logic [7:0] fetch_o
);
  // Vector 0 is the reset entry, never fetched as an interrupt
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fetch_o <= 8'h00;
    end else if (req_i && vec_i != 2'h0) begin
      fetch_o <= paddr_i;
    end
  end
endmodule // pivm_core_model
